/* File: hdl/gsp_pkg.sv */
package gsp_pkg;

    // register offsets on the host register port
    localparam logic [3:0] GSP_OFF_POLL = 4'h7;
    localparam logic [3:0] GSP_OFF_INTERRUPT_STATUS_TWO = 4'h3;

    // second interrupt status register fields
    localparam int GSP_INTERRUPT_STATUS_TWO_LOK_BIT = 5;
    localparam int GSP_INTERRUPT_STATUS_TWO_REM_BIT = 4;
    localparam int GSP_INTERRUPT_STATUS_TWO_LOCKOUT_CHANGE_FLAG_BIT = 2;
    localparam int GSP_INTERRUPT_STATUS_TWO_REMOTE_CHANGE_FLAG_BIT = 1;
    localparam int GSP_INTERRUPT_STATUS_TWO_ADDRESSED_CHANGE_FLAG_BIT = 0;

    // address status register bits watched for addressed changes
    localparam int GSP_ADDRESS_STATUS_REG_MAJOR_MINOR_SELECT_BIT = 0;
    localparam int GSP_ADDRESS_STATUS_REG_TA_BIT = 1;
    localparam int GSP_ADDRESS_STATUS_REG_LA_BIT = 2;
    localparam int GSP_ADDRESS_STATUS_REG_CIC_BIT = 7;

    // address mode register bits that suppress addressed changes
    localparam int GSP_ADDRESS_MODE_REG_LON_BIT = 6;
    localparam int GSP_ADDRESS_MODE_REG_TON_BIT = 7;

    // configuration register two
    localparam int GSP_CONFIGURATION_REG_TWO_LMR_BIT = 1;

    // poll response mode register fields
    localparam int GSP_POLL_RSV_BIT = 6;
    localparam int GSP_POLL_REQUEST_PENDING_BIT = 6;
    localparam logic [7:0] GSP_POLL_STB_MASK = 8'hbf;

    // reset values
    localparam logic [7:0] GSP_STB_RESET = 8'h00;
    localparam logic [2:0] GSP_FLAGS_RESET = 3'h0;
    localparam logic [2:0] GSP_IE_RESET = 3'h0;
    localparam logic [7:0] GSP_RDATA_RESET = 8'h00;

    // service request function states
    typedef enum logic [2:0] {
        GSP_NEG_POLL = 3'b001,
        GSP_SRV_REQ = 3'b010,
        GSP_AFF_POLL = 3'b100
    } gsp_sr_state_t;

endpackage

/* File: hdl/gsp_status_poll.sv */
`timescale 1ns/1ns

// Notes on behaviour
// - lockout-change flag (status two, bit 2) sets on any lockout status change.
// - remote-change flag (status two, bit 1) sets on any remote status change.
// - all three change flags clear at power-on and when status two is read.
// - addressed-change flag (bit 0) sets on talker, listener, controller or major/minor change.
// - watched address status bits are 1 talker, 2 listener, 7 controller, 0 major/minor.
// - no addressed-change flag while listen-only or talk-only mode is selected.
// - interrupt enables for the three flags sit at write bits 2, 1 and 0.
// - offset 7 reads the poll status view and writes the poll response mode.
// - status byte bits 7, 5-0 cleared by reset and chip reset, else hold writes.
// - when polled as talker, send full status byte once controller is standby.
// - pending bit, read bit 6, sets when host sets request-service bit.
// - pending clears in negative poll state with request serviced, showing byte sent.
// - request-service set and not being polled enters service request and drives SRQ.
// - request-service bit clears on entering affirmative poll response state.
// - request-service also cleared by power-on, local message reset and chip reset.
// - remote status true in remote state or remote-with-lockout state.
// - controller-in-charge true when controller is neither idle nor addressed-idle.
module gsp_status_poll
    import gsp_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // host register port
    input wire logic [3:0] host_addr,
    input wire logic host_rd,
    input wire logic host_wr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    output logic irq_req,
    // configuration and commands from the rest of the chip
    input wire logic [7:0] address_mode_reg,
    input wire logic [7:0] configuration_reg_two,
    input wire logic chip_reset_cmd,
    // interface function states
    input wire logic remote_state,
    input wire logic remote_lockout_state,
    input wire logic local_lockout_state,
    input wire logic ctl_idle_state,
    input wire logic ctl_addr_idle_state,
    input wire logic talker_active,
    input wire logic listener_active,
    input wire logic major_minor_select,
    input wire logic serial_poll_active,
    input wire logic poll_mode_state,
    // gpib side
    input wire logic atn_n_pin,
    input wire logic poll_byte_taken,
    output logic [7:0] poll_byte,
    output logic poll_byte_valid,
    output logic srq_o,
    output logic srq_oe,
    // status to the address status register
    output logic remote_status,
    output logic lockout_status,
    output logic controller_in_charge
);

    ////////////////////////////////////////////////////////////////////////////
    // decode

    logic rd_interrupt_status_two;
    logic wr_interrupt_status_two;
    logic rd_poll;
    logic wr_poll;
    logic addr_lock;

    assign rd_interrupt_status_two = host_rd && (host_addr == GSP_OFF_INTERRUPT_STATUS_TWO);
    assign wr_interrupt_status_two = host_wr && (host_addr == GSP_OFF_INTERRUPT_STATUS_TWO);
    assign rd_poll = host_rd && (host_addr == GSP_OFF_POLL);
    assign wr_poll = host_wr && (host_addr == GSP_OFF_POLL);
    assign addr_lock = address_mode_reg[GSP_ADDRESS_MODE_REG_LON_BIT]
        || address_mode_reg[GSP_ADDRESS_MODE_REG_TON_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // status derived from function states

    logic rem_now;
    logic lok_now;
    logic cic_now;

    assign rem_now = remote_state || remote_lockout_state;
    assign lok_now = local_lockout_state || remote_lockout_state;
    assign cic_now = !(ctl_idle_state || ctl_addr_idle_state);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            remote_status <= 1'b0;
            lockout_status <= 1'b0;
            controller_in_charge <= 1'b0;
        end else begin
            remote_status <= rem_now;
            lockout_status <= lok_now;
            controller_in_charge <= cic_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // change detection

    // the first cycle after reset only primes the history, so stale
    // zeros in it cannot raise a false change
    logic primed_reg;
    logic [5:0] watch_now;
    logic [5:0] watch_reg;
    logic [5:0] watch_diff;

    assign watch_now = {lok_now, rem_now, talker_active, listener_active,
        cic_now, major_minor_select};
    assign watch_diff = primed_reg ? (watch_now ^ watch_reg) : 6'h00;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            primed_reg <= 1'b0;
            watch_reg <= 6'h00;
        end else begin
            primed_reg <= 1'b1;
            watch_reg <= watch_now;
        end
    end

    logic [2:0] flag_set;
    logic [2:0] flags_reg;
    logic [2:0] irq_en_reg;

    assign flag_set[GSP_INTERRUPT_STATUS_TWO_LOCKOUT_CHANGE_FLAG_BIT] = watch_diff[5];
    assign flag_set[GSP_INTERRUPT_STATUS_TWO_REMOTE_CHANGE_FLAG_BIT] = watch_diff[4];
    assign flag_set[GSP_INTERRUPT_STATUS_TWO_ADDRESSED_CHANGE_FLAG_BIT] = (|watch_diff[3:0]) && !addr_lock;

    // a change in the read cycle survives the clear
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            flags_reg <= GSP_FLAGS_RESET;
        end else begin
            flags_reg <= (rd_interrupt_status_two ? 3'h0 : flags_reg) | flag_set;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irq_en_reg <= GSP_IE_RESET;
        end else if (wr_interrupt_status_two) begin
            irq_en_reg <= host_wdata[2:0];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= |(flags_reg & irq_en_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // poll response mode register

    logic [7:0] stb_reg;
    logic rsv_reg;
    logic request_pending_reg;
    gsp_sr_state_t sr_state_reg;
    logic enter_aff;

    assign enter_aff = (sr_state_reg == GSP_SRV_REQ) && serial_poll_active;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            stb_reg <= GSP_STB_RESET;
        end else if (chip_reset_cmd) begin
            stb_reg <= GSP_STB_RESET;
        end else if (wr_poll) begin
            stb_reg <= host_wdata & GSP_POLL_STB_MASK;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rsv_reg <= 1'b0;
        end else if (chip_reset_cmd || configuration_reg_two[GSP_CONFIGURATION_REG_TWO_LMR_BIT]) begin
            rsv_reg <= 1'b0;
        end else if (enter_aff) begin
            rsv_reg <= 1'b0;
        end else if (wr_poll) begin
            rsv_reg <= host_wdata[GSP_POLL_RSV_BIT];
        end
    end

    // pending clears once the request has been served and the function
    // is back in negative poll response
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            request_pending_reg <= 1'b0;
        end else if (wr_poll && host_wdata[GSP_POLL_RSV_BIT]) begin
            request_pending_reg <= 1'b1;
        end else if (sr_state_reg == GSP_NEG_POLL && !rsv_reg) begin
            request_pending_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // service request function

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sr_state_reg <= GSP_NEG_POLL;
        end else begin
            unique case (sr_state_reg)
                GSP_NEG_POLL: begin
                    if (rsv_reg && !serial_poll_active) begin
                        sr_state_reg <= GSP_SRV_REQ;
                    end
                end
                GSP_SRV_REQ: begin
                    if (serial_poll_active) begin
                        sr_state_reg <= GSP_AFF_POLL;
                    end else if (!rsv_reg) begin
                        sr_state_reg <= GSP_NEG_POLL;
                    end
                end
                GSP_AFF_POLL: begin
                    if (!serial_poll_active) begin
                        sr_state_reg <= GSP_NEG_POLL;
                    end
                end
                default: begin
                    sr_state_reg <= GSP_NEG_POLL;
                end
            endcase
        end
    end

    // srq is open drain: pull low only, never drive high
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            srq_oe <= 1'b0;
            srq_o <= 1'b0;
        end else begin
            srq_oe <= (sr_state_reg == GSP_SRV_REQ);
            srq_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status byte transmission

    logic atn_n_meta;
    logic atn_n_sync;
    logic sent_reg;
    logic send_ok;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            atn_n_meta <= 1'b0;
            atn_n_sync <= 1'b0;
        end else begin
            atn_n_meta <= atn_n_pin;
            atn_n_sync <= atn_n_meta;
        end
    end

    // controller in standby means atn released
    // atn is seen two cycles late, so poll mode must follow atn going low
    assign send_ok = poll_mode_state && talker_active && atn_n_sync && !sent_reg;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            poll_byte_valid <= 1'b0;
            poll_byte <= 8'h00;
            sent_reg <= 1'b0;
        end else begin
            if (!poll_mode_state) begin
                sent_reg <= 1'b0;
            end else if (poll_byte_valid && poll_byte_taken) begin
                sent_reg <= 1'b1;
            end
            if (poll_byte_valid && poll_byte_taken) begin
                poll_byte_valid <= 1'b0;
            end else if (send_ok && !poll_byte_valid) begin
                poll_byte_valid <= 1'b1;
                poll_byte <= stb_reg | ((sr_state_reg == GSP_AFF_POLL || enter_aff)
                    ? 8'h40 : 8'h00);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            host_rdata <= GSP_RDATA_RESET;
        end else if (rd_poll) begin
            host_rdata <= stb_reg | {1'b0, request_pending_reg, 6'h00};
        end else if (rd_interrupt_status_two) begin
            host_rdata <= {2'b00, lok_now, rem_now, 1'b0, flags_reg};
        end else if (host_rd) begin
            host_rdata <= GSP_RDATA_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    lok_change_a: assert property (primed_reg && $changed(lok_now)
        |=> flags_reg[GSP_INTERRUPT_STATUS_TWO_LOCKOUT_CHANGE_FLAG_BIT]) else $error("lockout change lost");
    rem_change_a: assert property (primed_reg && $changed(rem_now)
        |=> flags_reg[GSP_INTERRUPT_STATUS_TWO_REMOTE_CHANGE_FLAG_BIT]) else $error("remote change lost");
    read_clear_a: assert property (rd_interrupt_status_two && !(|flag_set)
        |=> flags_reg == 3'h0) else $error("read did not clear flags");
    addr_lock_a: assert property (addr_lock && !flags_reg[0]
        |=> !flags_reg[0]) else $error("addressed change in only mode");
    irq_follow_a: assert property (|(flags_reg & irq_en_reg)
        |=> irq_req) else $error("interrupt not raised");
    stb_hold_a: assert property (!wr_poll && !chip_reset_cmd
        |=> $stable(stb_reg)) else $error("status byte changed");
    srq_drive_a: assert property (sr_state_reg == GSP_SRV_REQ
        |=> srq_oe && !srq_o) else $error("srq not driven");
    rsv_aff_a: assert property (enter_aff && !wr_poll
        |=> !rsv_reg && sr_state_reg == GSP_AFF_POLL) else $error("rsv kept");
    request_pending_set_a: assert property (wr_poll && host_wdata[GSP_POLL_RSV_BIT]
        |=> request_pending_reg) else $error("pending not set");
    request_pending_clear_a: assert property (sr_state_reg == GSP_NEG_POLL && !rsv_reg
        && !wr_poll |=> !request_pending_reg) else $error("pending not cleared");
    stb_sent_a: assert property ($rose(poll_byte_valid)
        |-> (poll_byte & GSP_POLL_STB_MASK) == $past(stb_reg)) else $error("bad status byte");
    srq_release_a: assert property (sr_state_reg == GSP_AFF_POLL
        |=> !srq_oe) else $error("srq held in poll");

    srq_seen_c: cover property (sr_state_reg == GSP_SRV_REQ ##[1:20] enter_aff);
    byte_sent_c: cover property (poll_byte_valid && poll_byte_taken);
    irq_seen_c: cover property (irq_req ##1 rd_interrupt_status_two);
    request_pending_drop_c: cover property ($fell(request_pending_reg));

endmodule

/* File: test/gsp_ctrl_model.sv */
`timescale 1ns/1ns
module gsp_ctrl_model (
    // clock
    input wire logic clk_sys,
    // bench commands
    input wire logic start,
    input wire logic [3:0] lag,
    output logic done,
    output logic [7:0] got_byte,
    // gpib side of the block
    input wire logic [7:0] poll_byte,
    input wire logic poll_byte_valid,
    output logic atn_n_pin,
    output logic serial_poll_active,
    output logic poll_mode_state,
    output logic poll_byte_taken
);
    int n;
    logic early;
    initial begin
        {serial_poll_active, poll_mode_state, poll_byte_taken, done} = 4'h0;
        atn_n_pin = 1'b1;
        got_byte = 8'h00;
        forever begin
            @(posedge clk_sys);
            if (start) begin
                done <= 1'b0;
                // attention is taken before the poll enable goes out
                atn_n_pin <= 1'b0;
                repeat (3) @(posedge clk_sys);
                poll_mode_state <= 1'b1;
                serial_poll_active <= 1'b1;
                repeat (3) @(posedge clk_sys);
                // a byte offered before standby is marked bad below
                early = poll_byte_valid;
                // standby, now listening for the byte
                atn_n_pin <= 1'b1;
                n = 0;
                while (poll_byte_valid !== 1'b1 && n < 50) begin
                    @(posedge clk_sys);
                    n++;
                end
                // slow listener when lag is nonzero
                repeat (lag) @(posedge clk_sys);
                poll_byte_taken <= 1'b1;
                got_byte <= (poll_byte_valid === 1'b1 && early !== 1'b1) ? poll_byte : ~poll_byte;
                @(posedge clk_sys);
                poll_byte_taken <= 1'b0;
                atn_n_pin <= 1'b0;
                serial_poll_active <= 1'b0;
                poll_mode_state <= 1'b0;
                done <= 1'b1;
            end
        end
    end
endmodule

/* File: test/gsp_status_poll_tb.sv */
`timescale 1ns/1ns
module gsp_status_poll_tb;
    import gsp_pkg::*;
    logic clk_sys, resetn, host_rd, host_wr, chip_reset_cmd, start, irq_req, poll_byte_valid;
    logic srq_o, srq_oe, remote_status, lockout_status, controller_in_charge, done;
    logic atn_n_pin, serial_poll_active, poll_mode_state, poll_byte_taken;
    logic [3:0] host_addr, lag;
    logic [7:0] host_wdata, host_rdata, address_mode_reg, configuration_reg_two;
    logic [7:0] poll_byte, got_byte, fsm_in, rd, stb;
    logic [5:0] s;
    logic [2:0] flags, ie;
    int n_fail, compares;

    gsp_status_poll gsp_status_poll_inst (.clk_sys(clk_sys), .resetn(resetn),
        .host_addr(host_addr), .host_rd(host_rd), .host_wr(host_wr), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .irq_req(irq_req), .address_mode_reg(address_mode_reg),
        .configuration_reg_two(configuration_reg_two), .chip_reset_cmd(chip_reset_cmd),
        .remote_state(fsm_in[0]), .remote_lockout_state(fsm_in[1]),
        .local_lockout_state(fsm_in[2]), .ctl_idle_state(fsm_in[3]),
        .ctl_addr_idle_state(fsm_in[4]), .talker_active(fsm_in[5]),
        .listener_active(fsm_in[6]), .major_minor_select(fsm_in[7]),
        .serial_poll_active(serial_poll_active), .poll_mode_state(poll_mode_state),
        .atn_n_pin(atn_n_pin), .poll_byte_taken(poll_byte_taken), .poll_byte(poll_byte),
        .poll_byte_valid(poll_byte_valid), .srq_o(srq_o), .srq_oe(srq_oe),
        .remote_status(remote_status), .lockout_status(lockout_status),
        .controller_in_charge(controller_in_charge));

    gsp_ctrl_model gsp_ctrl_model_inst (.clk_sys(clk_sys), .start(start), .lag(lag),
        .done(done), .got_byte(got_byte), .poll_byte(poll_byte),
        .poll_byte_valid(poll_byte_valid), .atn_n_pin(atn_n_pin),
        .serial_poll_active(serial_poll_active), .poll_mode_state(poll_mode_state),
        .poll_byte_taken(poll_byte_taken));

    ////////////////////////////////////////////////////////////////////////////////
    // {lockout, remote, controller, talker, listener, major/minor}
    function automatic logic [5:0] st(input logic [7:0] v);
        return {v[2] | v[1], v[0] | v[1], !(v[3] | v[4]), v[5], v[6], v[7]};
    endfunction

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic host_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        host_addr <= a;
        host_wdata <= d;
        host_wr <= 1'b1;
        @(posedge clk_sys);
        host_wr <= 1'b0;
    endtask

    task automatic host_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        host_addr <= a;
        host_rd <= 1'b1;
        @(posedge clk_sys);
        host_rd <= 1'b0;
        @(negedge clk_sys);
        d = host_rdata;
    endtask

    // reference model: flags follow any change of the derived status bits, except addressed changes while listen-only or talk-only is set
    task automatic apply(input logic [7:0] nv);
        logic [5:0] d;
        d = st(fsm_in) ^ st(nv);
        @(posedge clk_sys);
        fsm_in <= nv;
        if (d[5]) flags[2] = 1'b1;
        if (d[4]) flags[1] = 1'b1;
        if (|d[3:0] && !(|address_mode_reg[7:6])) flags[0] = 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic check_isr;
        s = st(fsm_in);
        host_read(GSP_OFF_INTERRUPT_STATUS_TWO, rd);
        check("interrupt_status_two", {2'b00, s[5:4], 1'b0, flags}, rd);
        flags = 3'h0;
    endtask

    task automatic poll(input logic [3:0] l, input logic [7:0] exp);
        int n;
        @(posedge clk_sys);
        lag <= l;
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (done !== 1'b1 && n < 200);
        check("poll byte", exp, got_byte);
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic tally_and_finish;
        if (n_fail == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // whole run is well under a thousand cycles
    initial begin
        #(30000 * 50);
        n_fail++;
        tally_and_finish;
    end

    initial begin
        {resetn, host_rd, host_wr, chip_reset_cmd, start} = 5'h0;
        host_addr = 4'h0;
        lag = 4'h0;
        host_wdata = 8'h00;
        address_mode_reg = 8'h00;
        configuration_reg_two = 8'h00;
        fsm_in = 8'h08;
        flags = 3'h0;
        n_fail = 0;
        compares = 0;
        void'($urandom(32'hb9d7));
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        check_isr;
        host_read(GSP_OFF_POLL, rd);
        check("poll view", 8'h00, rd);
        for (int i = 0; i < 40; i++) begin
            @(posedge clk_sys);
            address_mode_reg <= ($urandom % 4 == 0) ? 8'h40 << ($urandom % 2) : 8'h00;
            ie = 3'($urandom);
            host_write(GSP_OFF_INTERRUPT_STATUS_TWO, {5'h0, ie});
            apply(fsm_in ^ (8'h01 << ($urandom % 8)));
            s = st(fsm_in);
            check("irq", {7'h0, |(flags & ie)}, {7'h0, irq_req});
            check("status", {5'h0, s[5:3]},
                {5'h0, lockout_status, remote_status, controller_in_charge});
            check_isr;
            repeat (2) @(posedge clk_sys);
            check("irq", 8'h00, {7'h0, irq_req});
        end
        @(posedge clk_sys);
        address_mode_reg <= 8'h00;
        apply(fsm_in | 8'h20);
        check_isr;
        stb = 8'($urandom) & GSP_POLL_STB_MASK;
        host_write(GSP_OFF_POLL, stb);
        host_read(GSP_OFF_POLL, rd);
        check("poll view", stb, rd);
        host_write(GSP_OFF_POLL, stb | 8'h40);
        repeat (4) @(posedge clk_sys);
        check("srq", 8'h01, {6'h0, srq_o, srq_oe});
        host_read(GSP_OFF_POLL, rd);
        check("pending", stb | 8'h40, rd);
        poll(4'h0, stb | 8'h40);
        check("srq", 8'h00, {6'h0, srq_o, srq_oe});
        host_read(GSP_OFF_POLL, rd);
        check("pending", stb, rd);
        poll(4'h6, stb);
        for (int k = 0; k < 2; k++) begin
            host_write(GSP_OFF_POLL, stb | 8'h40);
            repeat (4) @(posedge clk_sys);
            if (k == 0) configuration_reg_two <= 8'h02;
            else chip_reset_cmd <= 1'b1;
            @(posedge clk_sys);
            configuration_reg_two <= 8'h00;
            chip_reset_cmd <= 1'b0;
            repeat (4) @(posedge clk_sys);
            check("srq", 8'h00, {6'h0, srq_o, srq_oe});
            host_read(GSP_OFF_POLL, rd);
            check("poll view", (k == 0) ? stb : 8'h00, rd);
        end
        tally_and_finish;
    end
endmodule
